// ===== mmd_regs.svh
// Address map constants for the memory map decoder
// Operation
// - Decode 4 MByte program memory from segment 192 for fetches and constants.
// - Instruction fetches must use even word addresses.
// - Program memory words need even addresses, double words multiple-of-4 addresses.
// - Program memory only via indirect or long addressing, never short or bit.
// - Dual-port RAM 3 kByte at 00F200; top 256 bytes and bank bit addressable.
// - Dual-port RAM long/indirect access needs page pointer on data page 3.
// - Internal SRAM 24 kByte; long/indirect access needs data page 3 or 2.
// - Decode standard (00FE00..00FFFF) and extended (00F000..00F1FF) register blocks.
// - Short 8-bit register mode reaches words and low bytes, never high bytes.
// - Byte write to a special register clears the other byte.
// - Upper half of each register block bit addressable except top 16 words.
// - Extended switch redirects short and direct bit addressing to extended block.
// - Registers 0 to 15 reachable by short addresses in either block.
// - IO-region accesses bypass write-back buffers and caches.
// - IO read waits until pipeline speculation is resolved.
// - IO read, including bit instruction read phase, waits for pending IO writes.
// - IO: external 200000..3FFFFF, both register blocks, internal 00E000..00EFFF.
// - External IO does true byte transfers; internal IO does not.
// - Channel pointers pair in internal IO; byte write clears the other byte.
// - No fetches from dual-port RAM, SRAM, IO or register blocks.
// - Every unoccupied address goes to external memory.
// - External operands long/indirect only; aligned words and double words; no bits.
// - Segment 191 reads return 0000, writes suppressed, no external bus activity.
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_PMEM_SEG      8'hc0
`define MMD_PMEM_SEG_MASK 8'hc0
`define MMD_RSVD_SEG      8'hbf
`define MMD_XIO_LO        24'h200000
`define MMD_XIO_HI        24'h3fffff
`define MMD_SRAM_LO       24'h008000
`define MMD_SRAM_HI       24'h00dfff
`define MMD_IIO_LO        24'h00e000
`define MMD_IIO_HI        24'h00efff
`define MMD_XSR_LO        24'h00f000
`define MMD_XSR_HI        24'h00f1ff
`define MMD_DPR_LO        24'h00f200
`define MMD_DPR_HI        24'h00fdff
`define MMD_DPR_BIT_LO    24'h00fd00
`define MMD_SR_LO         24'h00fe00
`define MMD_SR_HI         24'h00ffff
`define MMD_BLK_BIT_LO    9'h100
`define MMD_BLK_BIT_HI    9'h1df
`define MMD_SHORT_BASE    24'h00fe00
`define MMD_XSHORT_BASE   24'h00f000
`define MMD_GPR_SHORT_LO  8'hf0
`define MMD_PAGE_DPR      10'h003
`define MMD_PAGE_SRAM     10'h002
`define MMD_READ_ZERO     16'h0000
`endif

// ===== mmd_pkg.sv
// Types for the memory map decoder
package mmd_pkg;
   typedef enum logic [7:0] {
      MMD_R_PMEM = 8'h01,
      MMD_R_DPR  = 8'h02,
      MMD_R_SRAM = 8'h04,
      MMD_R_SR   = 8'h08,
      MMD_R_XSR  = 8'h10,
      MMD_R_IIO  = 8'h20,
      MMD_R_EXT  = 8'h40,
      MMD_R_RSVD = 8'h80
   } mmd_region_e;
   typedef enum logic [2:0] {
      MMD_M_LONG  = 3'h1,
      MMD_M_SHORT = 3'h2,
      MMD_M_BIT   = 3'h4
   } mmd_mode_e;
   typedef enum logic [2:0] {
      MMD_S_IDLE  = 3'h1,
      MMD_S_HOLD  = 3'h2,
      MMD_S_ISSUE = 3'h4
   } mmd_state_e;
   typedef enum logic [1:0] {
      MMD_Z_BYTE  = 2'h0,
      MMD_Z_WORD  = 2'h1,
      MMD_Z_DWORD = 2'h2
   } mmd_size_e;
endpackage

// ===== mmd_region_decode.sv
// Combinational region classifier for a 24-bit physical address
`timescale 1ns/1ps
`include "mmd_regs.svh"
module mmd_region_decode
   import mmd_pkg::*;
(
   input  wire logic [23:0] addr,
   output mmd_region_e      region,
   output logic             is_io,
   output logic             bit_ok,
   output logic             fetch_ok
);
   always_comb begin
      // Order matters: reserved segment first, holes fall to external
      if (addr[23:16] == `MMD_RSVD_SEG) begin
         region = MMD_R_RSVD;
      end else if ((addr[23:16] & `MMD_PMEM_SEG_MASK) == `MMD_PMEM_SEG) begin
         region = MMD_R_PMEM;
      end else if (addr >= `MMD_SR_LO && addr <= `MMD_SR_HI) begin
         region = MMD_R_SR;
      end else if (addr >= `MMD_XSR_LO && addr <= `MMD_XSR_HI) begin
         region = MMD_R_XSR;
      end else if (addr >= `MMD_DPR_LO && addr <= `MMD_DPR_HI) begin
         region = MMD_R_DPR;
      end else if (addr >= `MMD_SRAM_LO && addr <= `MMD_SRAM_HI) begin
         region = MMD_R_SRAM;
      end else if (addr >= `MMD_IIO_LO && addr <= `MMD_IIO_HI) begin
         region = MMD_R_IIO;
      end else begin
         region = MMD_R_EXT;
      end
   end

   always_comb begin
      is_io = (region == MMD_R_SR) || (region == MMD_R_XSR) || (region == MMD_R_IIO)
              || (addr >= `MMD_XIO_LO && addr <= `MMD_XIO_HI);
      fetch_ok = (region == MMD_R_PMEM) || (region == MMD_R_EXT && !is_io);
      bit_ok = ((region == MMD_R_DPR) && (addr >= `MMD_DPR_BIT_LO))
               || (((region == MMD_R_SR) || (region == MMD_R_XSR))
                   && (addr[8:0] >= `MMD_BLK_BIT_LO) && (addr[8:0] <= `MMD_BLK_BIT_HI));
   end
endmodule

// ===== mmd_memory_map_decoder.sv
// Memory map decoder with access policy and IO read ordering
`timescale 1ns/1ps
`include "mmd_regs.svh"
module mmd_memory_map_decoder
   import mmd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_fetch,
   input  wire logic        req_write,
   input  wire logic        req_rmw,
   input  wire logic [2:0]  req_mode,
   input  wire logic [1:0]  req_size,
   input  wire logic [23:0] req_addr,
   input  wire logic [9:0]  req_page,
   input  wire logic        req_high_byte,
   input  wire logic [15:0] req_wdata,
   input  wire logic        ext_switch,
   input  wire logic        spec_pending,
   input  wire logic        io_wr_issue,
   input  wire logic        io_wr_done,
   input  wire logic        cpu_bank_hit,
   output logic             acc_valid,
   output logic [7:0]       acc_region,
   output logic [23:0]      acc_addr,
   output logic             acc_is_io,
   output logic             acc_bit_ok,
   output logic             acc_fetch_ok,
   output logic             acc_bypass_cache,
   output logic             acc_true_byte,
   output logic             acc_gpr,
   output logic [15:0]      acc_wdata,
   output logic [1:0]       acc_lane_en,
   output logic             acc_error,
   output logic             acc_suppress,
   output logic [15:0]      acc_rdata_zero
);
   // ****************************************************
   // Effective address
   // ****************************************************
   logic [23:0] eff_addr;
   logic        short_mode;
   logic        gpr_short;
   mmd_region_e region;
   logic        is_io;
   logic        bit_ok;
   logic        fetch_ok;

   assign short_mode = (req_mode == MMD_M_SHORT) || (req_mode == MMD_M_BIT);
   assign gpr_short  = short_mode && (req_addr[7:0] >= `MMD_GPR_SHORT_LO);

   always_comb begin
      if (short_mode) begin
         // Short offsets are word indexes into the selected block
         if (ext_switch) begin
            eff_addr = `MMD_XSHORT_BASE + {15'h0000, req_addr[7:0], 1'b0};
         end else begin
            eff_addr = `MMD_SHORT_BASE + {15'h0000, req_addr[7:0], 1'b0};
         end
      end else if (req_fetch) begin
         eff_addr = {req_addr[23:1], 1'b0};
      end else begin
         eff_addr = req_addr;
      end
   end

   mmd_region_decode mmd_region_decode_i (
      .addr     (eff_addr),
      .region   (region),
      .is_io    (is_io),
      .bit_ok   (bit_ok),
      .fetch_ok (fetch_ok)
   );

   // ****************************************************
   // Access policy
   // ****************************************************
   function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] a);
      misaligned = ((sz == MMD_Z_WORD) && a[0]) || ((sz == MMD_Z_DWORD) && (a != 2'h0));
   endfunction

   function automatic logic is_blk(input mmd_region_e r);
      is_blk = (r == MMD_R_SR) || (r == MMD_R_XSR);
   endfunction

   logic policy_err;
   always_comb begin
      policy_err = 1'b0;
      if (req_fetch) begin
         policy_err = !fetch_ok;
      end else if (gpr_short) begin
         policy_err = 1'b0;
      end else begin
         case (region)
            MMD_R_PMEM, MMD_R_EXT: begin
               policy_err = (req_mode != MMD_M_LONG) || misaligned(req_size, eff_addr[1:0]);
            end
            MMD_R_DPR: begin
               if (req_mode == MMD_M_LONG) begin
                  policy_err = (req_page != `MMD_PAGE_DPR) || misaligned(req_size, eff_addr[1:0]);
               end else begin
                  policy_err = !(bit_ok || cpu_bank_hit);
               end
            end
            MMD_R_SRAM: begin
               policy_err = (req_mode != MMD_M_LONG) || misaligned(req_size, eff_addr[1:0])
                            || !((req_page == `MMD_PAGE_DPR) || (req_page == `MMD_PAGE_SRAM));
            end
            MMD_R_SR, MMD_R_XSR: begin
               policy_err = ((req_mode == MMD_M_SHORT) && req_high_byte)
                            || ((req_mode == MMD_M_BIT) && !bit_ok)
                            || misaligned(req_size, eff_addr[1:0]);
            end
            MMD_R_IIO: begin
               policy_err = (req_mode != MMD_M_LONG) || misaligned(req_size, eff_addr[1:0]);
            end
            MMD_R_RSVD: begin
               policy_err = 1'b0;
            end
            default: begin
               policy_err = 1'b1;
            end
         endcase
      end
   end

   // ****************************************************
   // IO write tracking and read gating
   // ****************************************************
   logic [3:0] io_wr_cnt_reg;
   logic [3:0] io_wr_cnt_next;
   logic       io_read;
   logic       io_read_block;

   // Counter saturation is a limitation: no more than 15 writes in flight
   always_comb begin
      io_wr_cnt_next = io_wr_cnt_reg;
      if (io_wr_issue && !io_wr_done && io_wr_cnt_reg != 4'hf) begin
         io_wr_cnt_next = io_wr_cnt_reg + 4'h1;
      end else if (!io_wr_issue && io_wr_done && io_wr_cnt_reg != 4'h0) begin
         io_wr_cnt_next = io_wr_cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         io_wr_cnt_reg <= 4'h0;
      end else begin
         io_wr_cnt_reg <= io_wr_cnt_next;
      end
   end

   assign io_read = is_io && !req_fetch && (!req_write || req_rmw) && !gpr_short;
   assign io_read_block = io_read && (spec_pending
                          || (io_wr_cnt_reg != 4'h0) || io_wr_issue);

   // ****************************************************
   // Request state machine
   // ****************************************************
   mmd_state_e state_reg;
   mmd_state_e state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MMD_S_IDLE: begin
            if (req_valid && io_read_block) begin
               state_next = MMD_S_HOLD;
            end else if (req_valid) begin
               state_next = MMD_S_ISSUE;
            end
         end
         MMD_S_HOLD: begin
            if (!req_valid) begin
               state_next = MMD_S_IDLE;
            end else if (!io_read_block) begin
               state_next = MMD_S_ISSUE;
            end
         end
         MMD_S_ISSUE: begin
            if (req_valid && io_read_block) begin
               state_next = MMD_S_HOLD;
            end else if (!req_valid) begin
               state_next = MMD_S_IDLE;
            end
         end
         default: begin
            state_next = MMD_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= MMD_S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Accepted the same cycle unless an IO read must wait
   assign req_ready = !io_read_block;

   // ****************************************************
   // Lane enables and byte-write clearing
   // ****************************************************
   logic [1:0]  lane_en;
   logic [15:0] wdata;
   logic        clear_other;

   // Internal IO (incl. channel pointers) and register blocks have no true byte writes
   assign clear_other = is_blk(region) || (region == MMD_R_IIO);

   always_comb begin
      lane_en = 2'h3;
      wdata   = req_wdata;
      if (req_size == MMD_Z_BYTE && !gpr_short) begin
         if (clear_other && req_write && !req_rmw) begin
            lane_en = 2'h3;
            wdata   = eff_addr[0] ? {req_wdata[7:0], 8'h00} : {8'h00, req_wdata[7:0]};
         end else begin
            lane_en = eff_addr[0] ? 2'h2 : 2'h1;
            wdata   = eff_addr[0] ? {req_wdata[7:0], 8'h00} : {8'h00, req_wdata[7:0]};
         end
      end
   end

   // ****************************************************
   // Registered access outputs
   // ****************************************************
   logic fire;
   assign fire = req_valid && req_ready;

   always_ff @(posedge clk) begin
      if (rst) begin
         acc_valid        <= 1'b0;
         acc_region       <= 8'h00;
         acc_addr         <= 24'h000000;
         acc_is_io        <= 1'b0;
         acc_bit_ok       <= 1'b0;
         acc_fetch_ok     <= 1'b0;
         acc_bypass_cache <= 1'b0;
         acc_true_byte    <= 1'b0;
         acc_gpr          <= 1'b0;
         acc_wdata        <= 16'h0000;
         acc_lane_en      <= 2'h0;
         acc_error        <= 1'b0;
         acc_suppress     <= 1'b0;
      end else begin
         acc_valid <= fire;
         if (fire) begin
            acc_region       <= region;
            acc_addr         <= eff_addr;
            acc_is_io        <= is_io;
            acc_bit_ok       <= bit_ok || gpr_short;
            acc_fetch_ok     <= fetch_ok;
            acc_bypass_cache <= is_io;
            acc_true_byte    <= (req_size == MMD_Z_BYTE) && is_io && (region == MMD_R_EXT);
            acc_gpr          <= gpr_short;
            acc_wdata        <= wdata;
            acc_lane_en      <= lane_en;
            acc_error        <= policy_err;
            acc_suppress     <= (region == MMD_R_RSVD) || policy_err;
         end
      end
   end

   // Constant zero read value, driven whether or not the reserved segment is hit
   assign acc_rdata_zero = `MMD_READ_ZERO;
endmodule

// ===== mmd_cpu_model.sv
// CPU pipeline model that issues one access at a time
`timescale 1ns/1ps
module mmd_cpu_model (
   input  wire logic        clk,
   input  wire logic        req_ready,
   output logic             req_valid,
   output logic             req_fetch,
   output logic             req_write,
   output logic [2:0]       req_mode,
   output logic [1:0]       req_size,
   output logic [23:0]      req_addr,
   output logic [9:0]       req_page,
   output logic             req_high_byte,
   output logic [15:0]      req_wdata
);
   int waits = 0;
   initial begin
      {req_valid, req_fetch, req_write, req_high_byte} = 4'h0;
      {req_mode, req_size, req_addr, req_page, req_wdata} = 55'h0;
   end
   // Held until ready is seen or 100 waits pass; on release address and write data turn inverted so stale data never looks valid
   task automatic issue(input logic f, input logic w, input logic [2:0] m, input logic [1:0] s,
                        input logic [23:0] a, input logic [9:0] p, input logic h, input logic [15:0] d);
      @(negedge clk);
      {req_fetch, req_write, req_mode, req_size, req_addr} = {f, w, m, s, a};
      {req_page, req_high_byte, req_wdata} = {p, h, d};
      req_valid = 1'b1;
      waits = 0;
      #1;
      while (req_ready !== 1'b1 && waits < 100) begin
         @(negedge clk);
         #1;
         waits++;
      end
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      req_addr = ~req_addr;
      req_wdata = ~req_wdata;
   endtask
endmodule

// ===== mmd_decoder_props.sv
// Concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
module mmd_decoder_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_fetch,
   input wire logic        req_write,
   input wire logic [2:0]  req_mode,
   input wire logic [23:0] req_addr,
   input wire logic        spec_pending,
   input wire logic        io_wr_issue,
   input wire logic        acc_valid,
   input wire logic [7:0]  acc_region,
   input wire logic [23:0] acc_addr,
   input wire logic        acc_is_io,
   input wire logic        acc_bit_ok,
   input wire logic        acc_fetch_ok,
   input wire logic        acc_bypass_cache,
   input wire logic        acc_suppress,
   input wire logic [15:0] acc_rdata_zero
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Long read into internal IO, either register block or external IO
   wire io_rd = req_valid && !req_write && !req_fetch && req_mode == 3'h1 && (req_addr[23:12] == 12'h00e
                || req_addr[23:9] == 15'h007f || req_addr[23:9] == 15'h0078 || req_addr[23:21] == 3'h1);
   a_fire_answer: assert property (req_valid && req_ready |=> acc_valid) else $error("no answer");
   a_answer_cause: assert property (acc_valid |-> $past(req_valid && req_ready)) else $error("stray");
   a_region_onehot: assert property (acc_valid |-> $onehot(acc_region)) else $error("region");
   a_spec_blocks: assert property (io_rd && spec_pending |-> !req_ready) else $error("spec read");
   a_write_blocks: assert property (io_rd && io_wr_issue |-> !req_ready) else $error("wr order");
   a_io_bypass: assert property (acc_valid |-> acc_bypass_cache == acc_is_io) else $error("bypass");
   a_rsvd_quiet: assert property (acc_valid && acc_region == 8'h80 |-> acc_suppress) else $error("rsvd");
   a_zero_read: assert property (acc_rdata_zero == 16'h0000) else $error("zero");
   a_fetch_even: assert property (acc_valid && $past(req_fetch) |-> !acc_addr[0]) else $error("odd");
   a_no_io_fetch: assert property (acc_valid && acc_is_io |-> !acc_fetch_ok) else $error("io fetch");
   a_pmem_nobit: assert property (acc_valid && acc_region == 8'h01 |-> !acc_bit_ok && acc_fetch_ok)
      else $error("pmem flags");
   c_blocked: cover property (io_rd && !req_ready);
   c_rsvd: cover property (acc_valid && acc_region == 8'h80);
   c_fetch: cover property (acc_valid && acc_fetch_ok);
endmodule
bind mmd_memory_map_decoder mmd_decoder_props mmd_decoder_props_i (.clk, .rst, .req_valid, .req_ready,
   .req_fetch, .req_write, .req_mode, .req_addr, .spec_pending, .io_wr_issue, .acc_valid, .acc_region,
   .acc_addr, .acc_is_io, .acc_bit_ok, .acc_fetch_ok, .acc_bypass_cache, .acc_suppress, .acc_rdata_zero);

// ===== mmd_memory_map_decoder_tb_top.sv
// Self-checking testbench for the memory map decoder
`timescale 1ns/1ps
module mmd_memory_map_decoder_tb_top import mmd_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1;
   logic        ext_switch = 1'b0, spec_pending = 1'b0, io_wr_issue = 1'b0, io_wr_done = 1'b0;
   logic        req_rmw = 1'b0;
   logic        req_valid, req_ready, req_fetch, req_write, req_high_byte, acc_valid, acc_is_io;
   logic        acc_bit_ok, acc_fetch_ok, acc_bypass_cache, acc_true_byte, acc_gpr, acc_error, acc_suppress;
   logic [2:0]  req_mode;
   logic [1:0]  req_size, acc_lane_en;
   logic [23:0] req_addr, acc_addr;
   logic [9:0]  req_page;
   logic [15:0] req_wdata, acc_wdata, acc_rdata_zero;
   logic [7:0]  acc_region;
   int          failures = 0, cmp_count = 0, cycles = 0;
   // ********
   // Design and CPU model
   // ********
   mmd_memory_map_decoder mmd_memory_map_decoder_i (.clk, .rst, .req_valid, .req_ready, .req_fetch,
      .req_write, .req_rmw, .req_mode, .req_size, .req_addr, .req_page, .req_high_byte, .req_wdata,
      .ext_switch, .spec_pending, .io_wr_issue, .io_wr_done, .cpu_bank_hit(1'b0), .acc_valid, .acc_region,
      .acc_addr, .acc_is_io, .acc_bit_ok, .acc_fetch_ok, .acc_bypass_cache, .acc_true_byte, .acc_gpr,
      .acc_wdata, .acc_lane_en, .acc_error, .acc_suppress, .acc_rdata_zero);
   mmd_cpu_model mmd_cpu_model_i (.clk, .req_ready, .req_valid, .req_fetch, .req_write, .req_mode,
      .req_size, .req_addr, .req_page, .req_high_byte, .req_wdata);
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         complete_run();
      end
   end
   // ********
   // Shared tasks
   // ********
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic go(input logic f, input logic w, input logic [2:0] m, input logic [1:0] s, input logic [23:0] a,
                     input logic [9:0] p = 10'h003, input logic h = 1'b0, input logic [15:0] d = 16'h0000);
      mmd_cpu_model_i.issue(f, w, m, s, a, p, h, d);
      chk("valid", acc_valid, 1'b1);
   endtask
   task automatic rd(input logic [23:0] a, input logic [9:0] p = 10'h003);
      go(1'b0, 1'b0, MMD_M_LONG, MMD_Z_WORD, a, p);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_regions();
      logic [23:0] a [9] = '{24'hc00000, 24'h00f200, 24'h008000, 24'h00fe00, 24'h00f000, 24'h00e000,
                             24'h200000, 24'h100000, 24'hbf0000};
      logic [7:0]  r [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h40, 8'h80};
      logic [8:0]  io = 9'b001111000;
      for (int i = 0; i < 9; i++) begin
         rd(a[i]);
         chk("region", acc_region, r[i]);
         chk("io", acc_is_io, io[i]);
         chk("bypass", acc_bypass_cache, io[i]);
      end
      chk("suppress", acc_suppress, 1'b1);
      chk("rdata_zero", acc_rdata_zero, 24'h000000);
   endtask
   task automatic t_pages();
      rd(24'h00f200, 10'h002);
      chk("dpr_page", acc_error, 1'b1);
      rd(24'h008000, 10'h002);
      chk("sram_page2", acc_error, 1'b0);
      rd(24'h008000, 10'h001);
      chk("sram_page1", acc_error, 1'b1);
   endtask
   task automatic t_align();
      logic [1:0]  s [5] = '{MMD_Z_WORD, MMD_Z_DWORD, MMD_Z_DWORD, MMD_Z_WORD, MMD_Z_DWORD};
      logic [23:0] a [5] = '{24'hc00001, 24'hc00002, 24'hc00004, 24'h100001, 24'h100004};
      logic [4:0]  e = 5'b01011;
      for (int i = 0; i < 5; i++) begin
         go(1'b0, 1'b0, MMD_M_LONG, s[i], a[i]);
         chk("align", acc_error, e[i]);
      end
   endtask
   task automatic t_fetch();
      go(1'b1, 1'b0, MMD_M_LONG, MMD_Z_WORD, 24'hc00003);
      chk("fetch_addr", acc_addr, 24'hc00002);
      chk("fetch_pmem", acc_fetch_ok, 1'b1);
      go(1'b1, 1'b0, MMD_M_LONG, MMD_Z_WORD, 24'h00f200);
      chk("fetch_dpr", acc_fetch_ok, 1'b0);
      go(1'b1, 1'b0, MMD_M_LONG, MMD_Z_WORD, 24'h008000);
      chk("fetch_sram", acc_fetch_ok, 1'b0);
   endtask
   task automatic t_bytes();
      go(1'b0, 1'b1, MMD_M_LONG, MMD_Z_BYTE, 24'h00fe00, 10'h003, 1'b0, 16'h12ab);
      chk("sr_data", acc_wdata, 16'h00ab);
      chk("sr_lanes", acc_lane_en, 2'h3);
      go(1'b0, 1'b1, MMD_M_LONG, MMD_Z_BYTE, 24'h00e002, 10'h003, 1'b0, 16'h12ab);
      chk("ptr_data", acc_wdata, 16'h00ab);
      chk("iio_byte", acc_true_byte, 1'b0);
      go(1'b0, 1'b1, MMD_M_LONG, MMD_Z_BYTE, 24'h300001, 10'h003, 1'b0, 16'h0034);
      chk("xio_byte", acc_true_byte, 1'b1);
      chk("xio_lane", acc_lane_en, 2'h2);
   endtask
   task automatic t_short();
      go(1'b0, 1'b0, MMD_M_SHORT, MMD_Z_WORD, 24'h000010);
      chk("short_std", acc_addr, 24'h00fe20);
      ext_switch = 1'b1;
      go(1'b0, 1'b0, MMD_M_SHORT, MMD_Z_WORD, 24'h000010);
      chk("short_ext", acc_region, 8'h10);
      go(1'b0, 1'b0, MMD_M_SHORT, MMD_Z_WORD, 24'h0000f0);
      chk("gpr", acc_gpr, 1'b1);
      ext_switch = 1'b0;
      go(1'b0, 1'b0, MMD_M_SHORT, MMD_Z_BYTE, 24'h000010, 10'h003, 1'b1);
      chk("high_byte", acc_error, 1'b1);
      // Direct bit mode: offset 80 lands in the upper half, offset 10 in the lower
      go(1'b0, 1'b0, MMD_M_BIT, MMD_Z_WORD, 24'h000080);
      chk("bit_upper", acc_error, 1'b0);
      go(1'b0, 1'b0, MMD_M_BIT, MMD_Z_WORD, 24'h000010);
      chk("bit_lower", acc_error, 1'b1);
   endtask
   task automatic t_bits();
      logic [23:0] a [6] = '{24'h00fd00, 24'h00fc00, 24'h00ff00, 24'h00ffe0, 24'h00f100, 24'h00f000};
      logic [5:0]  e = 6'b010101;
      for (int i = 0; i < 6; i++) begin
         rd(a[i]);
         chk("bit_ok", acc_bit_ok, e[i]);
      end
   endtask
   task automatic t_io_order();
      spec_pending = 1'b1;
      rd(24'h008000);
      chk("spec_free", 24'(mmd_cpu_model_i.waits), 24'h0);
      fork
         rd(24'h00e000);
         begin
            repeat (6) @(negedge clk);
            spec_pending = 1'b0;
         end
      join
      chk("spec_wait", mmd_cpu_model_i.waits > 4, 1'b1);
      fork
         rd(24'h00e000);
         begin
            @(negedge clk);
            io_wr_issue = 1'b1;
            @(negedge clk);
            io_wr_issue = 1'b0;
            repeat (6) @(negedge clk);
            io_wr_done = 1'b1;
            @(negedge clk);
            io_wr_done = 1'b0;
         end
      join
      chk("wr_wait", mmd_cpu_model_i.waits > 6, 1'b1);
      // Read phase of a bit instruction must also wait behind a pending IO write
      req_rmw = 1'b1;
      fork
         go(1'b0, 1'b1, MMD_M_LONG, MMD_Z_WORD, 24'h00e000);
         begin
            @(negedge clk);
            io_wr_issue = 1'b1;
            @(negedge clk);
            io_wr_issue = 1'b0;
            repeat (3) @(negedge clk);
            io_wr_done = 1'b1;
            @(negedge clk);
            io_wr_done = 1'b0;
         end
      join
      req_rmw = 1'b0;
      chk("rmw_wait", mmd_cpu_model_i.waits > 3, 1'b1);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_regions();
      t_pages();
      t_align();
      t_fetch();
      t_bytes();
      t_short();
      t_bits();
      t_io_order();
      complete_run();
   end
endmodule
